// ===== rtl/itp_target.sv
`timescale 1ns/1ps
module itp_target import itp_pkg::*; (
  // System clock, reset, enable.
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Link clock that samples the serial pins.
  input wire logic i_lclk,
  // Serial pins and straps.
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [1:0] i_strap,
  // Register access port.
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  // Attention pin and event inputs.
  input wire logic i_event,
  input wire logic i_event_mask,
  output logic o_attn_n_o,
  output logic o_attn_n_oe
);
  // Reset copies for both domains, enable copy for the link domain only.
  logic [1:0] rst_sync_r;
  logic [1:0] lrst_sync_r;
  logic [1:0] lce_sync_r;
  wire rst_n = rst_sync_r[1];
  wire lrst_n = lrst_sync_r[1];
  wire lce = lce_sync_r[1];

  // Reset is released through two stages in each domain.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  always_ff @(posedge i_lclk or negedge i_resetn) begin
    if (!i_resetn) lrst_sync_r <= 2'h0;
    else lrst_sync_r <= {lrst_sync_r[0], 1'b1};
  end
  always_ff @(posedge i_lclk or negedge lrst_n) begin
    if (!lrst_n) lce_sync_r <= 2'h0;
    else lce_sync_r <= {lce_sync_r[0], i_ce};
  end

  // Pin synchronisers and spike filters, one per line (scl, sda).
  wire [1:0] pin_in = {i_scl, i_sda};
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_f_r;
  logic [1:0] pin_fd_r;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      logic [1:0] cnt_r;
      // A new level is taken only after it holds for FILT_CYC samples, longer than a spike.
      always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
          pin_s1_r[g] <= 1'b1;
          pin_s2_r[g] <= 1'b1;
          pin_f_r[g] <= 1'b1;
          cnt_r <= FILT_ZERO;
        end else if (lce) begin
          pin_s1_r[g] <= pin_in[g];
          pin_s2_r[g] <= pin_s1_r[g];
          if (pin_s2_r[g] == pin_f_r[g]) cnt_r <= FILT_ZERO;
          else if (cnt_r == FILT_LAST) begin
            pin_f_r[g] <= pin_s2_r[g];
            cnt_r <= FILT_ZERO;
          end else cnt_r <= cnt_r + FILT_STEP;
        end
      end
    end
  endgenerate

  // Strap pins pass two stages as well.
  logic [1:0] strap_s1_r;
  logic [1:0] strap_s2_r;
  always_ff @(posedge i_lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      strap_s1_r <= STRAP_00;
      strap_s2_r <= STRAP_00;
      pin_fd_r <= 2'h3;
    end else if (lce) begin
      strap_s1_r <= i_strap;
      strap_s2_r <= strap_s1_r;
      pin_fd_r <= pin_f_r;
    end
  end

  // Bus events from the filtered lines.
  wire scl_f = pin_f_r[1];
  wire sda_f = pin_f_r[0];
  wire scl_rise = scl_f && !pin_fd_r[1];
  wire scl_fall = !scl_f && pin_fd_r[1];
  wire start_det = scl_f && pin_fd_r[1] && pin_fd_r[0] && !sda_f;
  wire stop_det = scl_f && pin_fd_r[1] && !pin_fd_r[0] && sda_f;
  wire [6:0] my_addr = (strap_s2_r == STRAP_00) ? ADDR_00 :
                       (strap_s2_r == STRAP_01) ? ADDR_01 :
                       (strap_s2_r == STRAP_10) ? ADDR_10 : ADDR_11;

  // Serial engine state.
  itp_state_t state_r;
  itp_state_t after_ack_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic sda_oe_r;
  logic lreq_tgl_r;
  logic lreq_wr_r;
  logic [7:0] lreq_addr_r;
  logic [7:0] lreq_data_r;
  logic [2:0] lack_sync_r;
  logic ack_tgl_r;
  logic [7:0] rdata_r;
  wire byte_done = scl_fall && (cnt_r == BYTE_BITS);
  wire addr_hit = (sh_r[7:1] == my_addr);
  wire ack_seen = lack_sync_r[2] != lack_sync_r[1];

  // Acknowledge toggle from the system side, edge taken after two stages.
  always_ff @(posedge i_lclk or negedge lrst_n) begin
    if (!lrst_n) lack_sync_r <= 3'h0;
    else if (lce) lack_sync_r <= {lack_sync_r[1:0], ack_tgl_r};
  end

  // Engine: receive bytes, drive acknowledges, fetch and send read bytes.
  always_ff @(posedge i_lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= PTR_RESET;
      sda_oe_r <= 1'b0;
      lreq_tgl_r <= 1'b0;
      lreq_wr_r <= 1'b0;
      lreq_addr_r <= PTR_RESET;
      lreq_data_r <= 8'h00;
    end else if (lce) begin
      if (stop_det) begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_det) begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_f};
              cnt_r <= cnt_r + 4'h1;
            end else if (byte_done) begin
              state_r <= ST_ACK;
              sda_oe_r <= 1'b1;
              if (state_r == ST_ADDR) begin
                if (!addr_hit) begin
                  state_r <= ST_IDLE;
                  sda_oe_r <= 1'b0;
                end
                after_ack_r <= sh_r[0] ? ST_RFETCH : ST_REG;
              end else if (state_r == ST_REG) begin
                ptr_r <= sh_r;
                after_ack_r <= ST_WDATA;
              end else begin
                lreq_wr_r <= 1'b1;
                lreq_addr_r <= ptr_r;
                lreq_data_r <= sh_r;
                lreq_tgl_r <= !lreq_tgl_r;
                ptr_r <= ptr_r + PTR_STEP;
                after_ack_r <= ST_WDATA;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              cnt_r <= 4'h0;
              state_r <= after_ack_r;
              if (after_ack_r == ST_RFETCH) begin
                lreq_wr_r <= 1'b0;
                lreq_addr_r <= ptr_r;
                lreq_tgl_r <= !lreq_tgl_r;
              end
            end
          end
          ST_RFETCH: begin
            // The fetch returns well inside the clock low time, so no stretching is needed.
            if (ack_seen) begin
              sh_r <= rdata_r;
              sda_oe_r <= !rdata_r[7];
              ptr_r <= ptr_r + PTR_STEP;
              cnt_r <= 4'h0;
              state_r <= ST_RDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (cnt_r == LAST_TX_BIT) begin
                sda_oe_r <= 1'b0;
                state_r <= ST_RACK;
              end else begin
                sh_r <= {sh_r[6:0], 1'b0};
                sda_oe_r <= !sh_r[6];
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) state_r <= sda_f ? ST_IDLE : ST_RNEXT;
          end
          ST_RNEXT: begin
            if (scl_fall) begin
              lreq_wr_r <= 1'b0;
              lreq_addr_r <= ptr_r;
              lreq_tgl_r <= !lreq_tgl_r;
              state_r <= ST_RFETCH;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Request toggle into the system domain; address and data are stable by then.
  logic [2:0] req_sync_r;
  logic reg_wr_r;
  logic reg_rd_r;
  logic [7:0] reg_addr_r;
  logic [7:0] reg_wdata_r;
  wire req_seen = req_sync_r[2] != req_sync_r[1];
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync_r <= 3'h0;
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
      reg_addr_r <= PTR_RESET;
      reg_wdata_r <= 8'h00;
    end else if (i_ce) begin
      req_sync_r <= {req_sync_r[1:0], lreq_tgl_r};
      reg_wr_r <= req_seen && lreq_wr_r;
      reg_rd_r <= req_seen && !lreq_wr_r;
      if (req_seen) begin
        reg_addr_r <= lreq_addr_r;
        reg_wdata_r <= lreq_data_r;
      end
    end
  end

  // Read data is caught with the strobe and acknowledged by toggle in the same cycle.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      ack_tgl_r <= 1'b0;
    end else if (i_ce) begin
      if (reg_rd_r) rdata_r <= i_reg_rdata;
      if (reg_rd_r || reg_wr_r) ack_tgl_r <= !ack_tgl_r;
    end
  end

  // Attention: sticky pending, set wins over the clearing read.
  logic pend_r;
  logic attn_oe_r;
  wire evt_clear = reg_rd_r && (reg_addr_r == EVENT_REG_ADDR);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      attn_oe_r <= 1'b0;
    end else if (i_ce) begin
      pend_r <= i_event || (pend_r && !evt_clear);
      attn_oe_r <= pend_r && !i_event_mask;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_r;
  assign o_reg_wr = reg_wr_r;
  assign o_reg_rd = reg_rd_r;
  assign o_reg_addr = reg_addr_r;
  assign o_reg_wdata = reg_wdata_r;
  assign o_attn_n_o = 1'b0;
  assign o_attn_n_oe = attn_oe_r;

  // Checks on the link domain.
  sequence s_addr_byte_hit;
    state_r == ST_ADDR && byte_done && addr_hit;
  endsequence
  a_ack_own_addr: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    lce && !start_det && !stop_det ##0 s_addr_byte_hit |=> sda_oe_r && state_r == ST_ACK)
    else $error("own address not acknowledged");
  a_foreign_ignored: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    lce && !start_det && !stop_det && state_r == ST_ADDR && byte_done && !addr_hit
    |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("foreign address not ignored");
  a_addr_strap_map: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    lce && !start_det && !stop_det && state_r == ST_ADDR && byte_done
    && strap_s2_r == STRAP_10 && sh_r[7:1] == ADDR_10 |=> sda_oe_r)
    else $error("strap address not acknowledged");
  a_write_ptr_step: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    lce && !start_det && !stop_det && state_r == ST_WDATA && byte_done
    |=> ptr_r == $past(ptr_r) + PTR_STEP && lreq_wr_r && lreq_data_r == $past(sh_r))
    else $error("write pointer not advanced");
  a_stop_release: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    lce && stop_det |=> !sda_oe_r && state_r == ST_IDLE)
    else $error("stop did not release data line");
  a_nack_ends: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    lce && !start_det && !stop_det && state_r == ST_RACK && scl_rise && sda_f
    |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("not_acknowledge did not end read");
  a_spike_filter: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    lce && $changed(pin_f_r[1]) |-> $past(pin_s2_r[1], 1) == pin_f_r[1]
    && $past(pin_s2_r[1], 2) == pin_f_r[1] && $past(pin_s2_r[1], 3) == pin_f_r[1])
    else $error("clock change shorter than filter");
  a_read_load: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    lce && !start_det && !stop_det && state_r == ST_RFETCH && ack_seen
    |=> sh_r == $past(rdata_r) && ptr_r == $past(ptr_r) + PTR_STEP)
    else $error("read byte not loaded");
  // Checks on the system domain.
  sequence s_event_pending;
    i_ce && pend_r && !i_event_mask;
  endsequence
  a_attn_drive: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_event_pending |=> o_attn_n_oe)
    else $error("attention not driven");
  a_attn_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce && evt_clear && !i_event |=> !pend_r)
    else $error("event read did not clear");
endmodule

// ===== rtl/itp_pkg.sv
package itp_pkg;
  // Target addresses picked by the two strap pins.
  localparam logic [1:0] STRAP_00 = 2'h0;
  localparam logic [1:0] STRAP_01 = 2'h1;
  localparam logic [1:0] STRAP_10 = 2'h2;
  localparam logic [6:0] ADDR_00 = 7'h42;
  localparam logic [6:0] ADDR_01 = 7'h43;
  localparam logic [6:0] ADDR_10 = 7'h45;
  localparam logic [6:0] ADDR_11 = 7'h54;
  // Byte framing on the serial port.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  // Reading this register clears the attention output.
  localparam logic [7:0] EVENT_REG_ADDR = 8'h04;
  // Spike filter, counted on the link clock.
  localparam int SPIKE_NS = 50;
  localparam int LCLK_NS = 32;
  localparam int FILT_CYC = (SPIKE_NS + LCLK_NS - 1) / LCLK_NS + 1;
  localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);
  localparam logic [1:0] FILT_ZERO = 2'h0;
  localparam logic [1:0] FILT_STEP = 2'h1;
  // Serial engine states.
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RFETCH, ST_RDATA, ST_RACK, ST_RNEXT
  } itp_state_t;
endpackage

// ===== tb/itp_host_model.sv
`timescale 1ns/1ps
// Bus controller model. The data line has a pull-up, so a released line reads high; the clock is driven directly.
module itp_host_model (
  // Clock and the device pull on the data line.
  input wire logic i_clk,
  input wire logic i_dev_pull,
  // Resolved bus lines.
  output logic o_scl,
  output logic o_sda
);
  logic host_sda_r = 1'b1;
  logic spike = 1'b0;
  initial o_scl = 1'b1;
  // Wired AND of both parties.
  assign o_sda = host_sda_r & ~i_dev_pull;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One bit slot: 1.5 us low, 1 us high, so the clock stays at 400 kHz.
  // An optional 50 ns clock spike, the widest that must be ignored.
  task automatic slot(input logic b, output logic r);
    tick(15);
    host_sda_r <= b;
    if (spike) begin
      tick(10);
      o_scl <= 1'b1;
      tick(2);
      o_scl <= 1'b0;
      spike = 1'b0;
    end
    tick(45);
    o_scl <= 1'b1;
    tick(40);
    r = o_sda;
    o_scl <= 1'b0;
  endtask
  // Start or repeated start.
  task automatic start();
    tick(15);
    host_sda_r <= 1'b1;
    tick(30);
    o_scl <= 1'b1;
    tick(30);
    host_sda_r <= 1'b0;
    tick(30);
    o_scl <= 1'b0;
  endtask
  // Stop, then bus-free time.
  task automatic stop();
    tick(15);
    host_sda_r <= 1'b0;
    tick(30);
    o_scl <= 1'b1;
    tick(30);
    host_sda_r <= 1'b1;
    tick(60);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) slot(d[i], r);
    slot(1'b1, r);
    ack = ~r;
  endtask
  // The last wanted byte gets a not_acknowledge.
  task automatic rd(input logic not_acknowledge, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, r);
      d[i] = r;
    end
    slot(not_acknowledge, r);
  endtask
endmodule

// ===== tb/i2c_register_target_port_tb.sv
`timescale 1ns/1ps
module i2c_register_target_port_tb import itp_pkg::*;;
  logic i_clk, i_lclk, i_resetn, i_ce, i_event, i_event_mask;
  logic [1:0] i_strap;
  logic scl, sda, sda_o, sda_oe, reg_wr, reg_rd, attn_o, attn_oe;
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] regs [256];
  logic [6:0] adr_tab [4] = '{ADDR_00, ADDR_01, ADDR_10, ADDR_11};
  logic [6:0] dev;
  logic [15:0] seed = 16'hd128;
  logic a;
  int mem [256];
  int ptr;
  int miscompares = 0;
  int samples_checked = 0;
  int rd_seen = 0;
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Link clock runs free, out of phase with the system clock.
  initial begin
    i_lclk = 1'b0;
    #7;
    forever #16 i_lclk = ~i_lclk;
  end
  // User registers answer combinationally, as the read port expects; read strobes are counted.
  always @(posedge i_clk) begin
    if (reg_wr) regs[reg_addr] <= reg_wdata;
    if (reg_rd) rd_seen++;
  end
  // The device pulls the data line only while enabled and driving its low level.
  itp_host_model u_host (.i_clk(i_clk), .i_dev_pull(sda_oe & ~sda_o), .o_scl(scl), .o_sda(sda));
  itp_target u_itp_target (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_lclk(i_lclk),
    .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_strap(i_strap),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .i_reg_rdata(regs[reg_addr]), .i_event(i_event), .i_event_mask(i_event_mask),
    .o_attn_n_o(attn_o), .o_attn_n_oe(attn_oe));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Pointer byte k, then n random data bytes kept in the model.
  task automatic xwrite(input int k, input int n);
    u_host.start();
    u_host.wr({dev, 1'b0}, a);
    check(8'(a), 8'h01);
    u_host.wr(8'(k), a);
    check(8'(a), 8'h01);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      mem[k + i] = int'(seed[7:0]);
      if (i == 0) u_host.spike = 1'b1;
      u_host.wr(seed[7:0], a);
      check(8'(a), 8'h01);
    end
    u_host.stop();
    ptr = k + n;
    for (int i = 0; i < n; i++) check(regs[k + i], 8'(mem[k + i]));
  endtask
  // Read n bytes, optionally after a pointer phase and repeated start.
  task automatic xread(input logic setp, input int k, input int n);
    logic [7:0] d;
    int r0;
    r0 = rd_seen;
    if (setp) begin
      u_host.start();
      u_host.wr({dev, 1'b0}, a);
      u_host.wr(8'(k), a);
      ptr = k;
    end
    u_host.start();
    u_host.wr({dev, 1'b1}, a);
    check(8'(a), 8'h01);
    for (int i = 0; i < n; i++) begin
      u_host.rd(i == n - 1, d);
      check(d, 8'(mem[ptr]));
      ptr = (ptr + 1) % 256;
    end
    u_host.stop();
    check(8'(rd_seen - r0), 8'(n));
  endtask
  // Hang guard.
  initial begin
    repeat (90000) @(posedge i_clk);
    miscompares++;
    test_done();
  end
  initial begin
    int k;
    i_resetn = 1'b0;
    i_ce = 1'b1;
    i_strap = 2'h0;
    i_event = 1'b0;
    i_event_mask = 1'b0;
    for (int i = 0; i < 256; i++) begin
      seed = lfsr(seed);
      regs[i] = seed[7:0];
      mem[i] = int'(seed[7:0]);
    end
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (20) @(posedge i_clk);
    // Every strap code: a foreign address is ignored, the own one answered.
    for (int s = 0; s < 4; s++) begin
      i_strap <= 2'(s);
      dev = adr_tab[s];
      repeat (10) @(posedge i_clk);
      u_host.start();
      u_host.wr({dev ^ 7'h01, 1'b0}, a);
      u_host.stop();
      check(8'(a), 8'h00);
      xwrite(16 + s, 1);
    end
    $display("test strap done");
    // Test registers stay clear of the event register.
    k = 32 + int'(seed[6:0]);
    xwrite(k, 3);
    xread(1'b1, k, 3);
    xread(1'b0, 0, 2);
    $display("test burst done");
    // A frozen block misses an event pulse, so the attention pin stays released.
    i_ce <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_event <= 1'b1;
    @(posedge i_clk);
    i_event <= 1'b0;
    i_ce <= 1'b1;
    repeat (4) @(posedge i_clk);
    check(8'(attn_oe & ~attn_o), 8'h00);
    $display("test freeze done");
    // A masked event stays pending and shows once unmasked.
    i_event_mask <= 1'b1;
    i_event <= 1'b1;
    @(posedge i_clk);
    i_event <= 1'b0;
    repeat (4) @(posedge i_clk);
    check(8'(attn_oe & ~attn_o), 8'h00);
    i_event_mask <= 1'b0;
    repeat (3) @(posedge i_clk);
    check(8'(attn_oe & ~attn_o), 8'h01);
    xread(1'b1, int'(EVENT_REG_ADDR), 1);
    check(8'(attn_oe & ~attn_o), 8'h00);
    $display("test attention done");
    test_done();
  end
endmodule
